// File: logic/calsu_pkg.sv
/*
  Package for the arithmetic, logic and shift unit: operation codes,
  flag positions, step and decimal fix constants and reset values.
  Assumes the decoder maps each instruction onto one calsu_op_e value.
*/
package calsu_pkg;
  typedef enum logic [4:0] {
    OP_NONE,
    OP_ADD,
    OP_SUB,
    OP_ADD_WITH_CARRY,
    OP_SUBTRACT_WITH_BORROW,
    OP_PLUS_ONE,
    OP_MINUS_ONE_OP,
    OP_WORD_SMALL_STEP_PLUS,
    OP_WORD_SMALL_STEP_MINUS,
    OP_DECIMAL_FIX_AFTER_ADD,
    OP_DECIMAL_FIX_AFTER_SUB,
    OP_UNSIGNED_MULTIPLY,
    OP_UNSIGNED_DIVIDE,
    OP_COMPARE_OP,
    OP_NEGATE,
    OP_AND,
    OP_OR,
    OP_XOR,
    OP_NOT,
    OP_ARITH_SHIFT_LEFT,
    OP_ARITH_SHIFT_RIGHT,
    OP_LOGIC_SHIFT_LEFT,
    OP_LOGIC_SHIFT_RIGHT,
    OP_ROTATE_LEFT,
    OP_ROTATE_RIGHT,
    OP_ROTATE_LEFT_VIA_CARRY,
    OP_ROTATE_RIGHT_VIA_CARRY
  } calsu_op_e;

  // Flag positions inside the condition code byte
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_H = 5;

  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [7:0] CCR_RST = 8'h00;
  localparam logic [15:0] STEP_ONE = 16'h0001;
  localparam logic [15:0] STEP_TWO = 16'h0002;
  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
endpackage

// File: logic/calsu_unit.sv
/*
  Arithmetic, logic and shift datapath of the processor core.
  Assumes the decoder presents one operation per cycle with start_i high,
  operands already read from the register file, and writes result_o back
  to the destination when wr_en_o is high. One cycle latency.
*/
`timescale 1ns/10ps
module calsu_unit (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire calsu_pkg::calsu_op_e op_i,
  input wire logic word_i,
  input wire logic imm_i,
  input wire logic [15:0] dst_i,
  input wire logic [15:0] src_i,
  input wire logic [7:0] ccr_i,
  output logic [15:0] result_o,
  output logic [7:0] ccr_o,
  output logic wr_en_o,
  output logic done_o,
  output logic illegal_o
);
  logic [15:0] result_ff;
  logic [15:0] nxt_result;
  logic [7:0] ccr_ff;
  logic [7:0] nxt_ccr;
  logic wr_en_ff;
  logic nxt_wr_en;
  logic done_ff;
  logic nxt_done;
  logic illegal_ff;
  logic nxt_illegal;

  always_comb
  begin
    logic [16:0] sum;
    logic [8:0] bsum;
    logic [4:0] hsum;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] r8;
    logic [7:0] fix;
    logic cin;
    logic bad;
    logic sub;
    logic arith;
    logic logic_op;
    logic cout;
    sum = 17'h00000;
    bsum = 9'h000;
    hsum = 5'h00;
    a = dst_i[7:0];
    b = src_i[7:0];
    r8 = 8'h00;
    fix = 8'h00;
    cin = ccr_i[calsu_pkg::FLAG_C];
    bad = 1'b0;
    sub = 1'b0;
    arith = 1'b0;
    logic_op = 1'b0;
    cout = 1'b0;
    nxt_result = dst_i;
    nxt_ccr = ccr_i;
    nxt_wr_en = start_i;
    nxt_done = start_i;
    unique case (op_i)
      calsu_pkg::OP_ADD, calsu_pkg::OP_SUB, calsu_pkg::OP_COMPARE_OP:
      begin
        sub = (op_i != calsu_pkg::OP_ADD);
        bad = (word_i && imm_i) || (op_i == calsu_pkg::OP_SUB && imm_i);
        arith = 1'b1;
      end
      calsu_pkg::OP_ADD_WITH_CARRY, calsu_pkg::OP_SUBTRACT_WITH_BORROW:
      begin
        sub = (op_i == calsu_pkg::OP_SUBTRACT_WITH_BORROW);
        bad = word_i;
        arith = 1'b1;
      end
      calsu_pkg::OP_PLUS_ONE, calsu_pkg::OP_MINUS_ONE_OP:
      begin
        sub = (op_i == calsu_pkg::OP_MINUS_ONE_OP);
        b = 8'h01;
        bad = word_i;
        arith = 1'b1;
      end
      calsu_pkg::OP_WORD_SMALL_STEP_PLUS, calsu_pkg::OP_WORD_SMALL_STEP_MINUS:
      begin
        bad = (src_i != calsu_pkg::STEP_ONE) && (src_i != calsu_pkg::STEP_TWO);
        if (op_i == calsu_pkg::OP_WORD_SMALL_STEP_PLUS)
          nxt_result = dst_i + src_i;
        else
          nxt_result = dst_i - src_i;
      end
      calsu_pkg::OP_DECIMAL_FIX_AFTER_ADD, calsu_pkg::OP_DECIMAL_FIX_AFTER_SUB:
      begin
        cout = ccr_i[calsu_pkg::FLAG_C];
        if (ccr_i[calsu_pkg::FLAG_H] || (op_i == calsu_pkg::OP_DECIMAL_FIX_AFTER_ADD
            && a[3:0] > 4'h9))
          fix = calsu_pkg::BCD_LOW_FIX;
        if (cout || (op_i == calsu_pkg::OP_DECIMAL_FIX_AFTER_ADD && a > 8'h99))
        begin
          fix = fix | calsu_pkg::BCD_HIGH_FIX;
          cout = 1'b1;
        end
        r8 = (op_i == calsu_pkg::OP_DECIMAL_FIX_AFTER_ADD) ? a + fix : a - fix;
        nxt_result = {dst_i[15:8], r8};
        nxt_ccr[calsu_pkg::FLAG_C] = cout;
        logic_op = 1'b1;
      end
      calsu_pkg::OP_UNSIGNED_MULTIPLY:
        nxt_result = {8'h00, a} * {8'h00, b};
      calsu_pkg::OP_UNSIGNED_DIVIDE:
      begin
        // Divide by zero leaves the destination unchanged and flags it
        bad = (b == 8'h00);
        if (!bad)
          nxt_result = {8'((dst_i % {8'h00, b})), 8'((dst_i / {8'h00, b}))};
      end
      calsu_pkg::OP_NEGATE:
      begin
        a = 8'h00;
        b = dst_i[7:0];
        sub = 1'b1;
        arith = 1'b1;
      end
      calsu_pkg::OP_AND, calsu_pkg::OP_OR, calsu_pkg::OP_XOR, calsu_pkg::OP_NOT:
      begin
        unique case (op_i)
          calsu_pkg::OP_AND: r8 = a & b;
          calsu_pkg::OP_OR: r8 = a | b;
          calsu_pkg::OP_XOR: r8 = a ^ b;
          default: r8 = ~a;
        endcase
        nxt_result = {dst_i[15:8], r8};
        nxt_ccr[calsu_pkg::FLAG_V] = 1'b0;
        logic_op = 1'b1;
      end
      calsu_pkg::OP_ARITH_SHIFT_LEFT, calsu_pkg::OP_LOGIC_SHIFT_LEFT,
      calsu_pkg::OP_ROTATE_LEFT, calsu_pkg::OP_ROTATE_LEFT_VIA_CARRY:
      begin
        cout = a[7];
        unique case (op_i)
          calsu_pkg::OP_ROTATE_LEFT: r8 = {a[6:0], a[7]};
          calsu_pkg::OP_ROTATE_LEFT_VIA_CARRY: r8 = {a[6:0], cin};
          default: r8 = {a[6:0], 1'b0};
        endcase
        nxt_result = {dst_i[15:8], r8};
        nxt_ccr[calsu_pkg::FLAG_C] = cout;
        nxt_ccr[calsu_pkg::FLAG_V] = 1'b0;
        logic_op = 1'b1;
      end
      calsu_pkg::OP_ARITH_SHIFT_RIGHT, calsu_pkg::OP_LOGIC_SHIFT_RIGHT,
      calsu_pkg::OP_ROTATE_RIGHT, calsu_pkg::OP_ROTATE_RIGHT_VIA_CARRY:
      begin
        cout = a[0];
        unique case (op_i)
          calsu_pkg::OP_ARITH_SHIFT_RIGHT: r8 = {a[7], a[7:1]};
          calsu_pkg::OP_ROTATE_RIGHT: r8 = {a[0], a[7:1]};
          calsu_pkg::OP_ROTATE_RIGHT_VIA_CARRY: r8 = {cin, a[7:1]};
          default: r8 = {1'b0, a[7:1]};
        endcase
        nxt_result = {dst_i[15:8], r8};
        nxt_ccr[calsu_pkg::FLAG_C] = cout;
        nxt_ccr[calsu_pkg::FLAG_V] = 1'b0;
        logic_op = 1'b1;
      end
      default:
      begin
        nxt_wr_en = 1'b0;
        nxt_done = 1'b0;
      end
    endcase
    if (arith && word_i && !bad)
    begin
      sum = sub ? {1'b0, dst_i} - {1'b0, src_i} : {1'b0, dst_i} + {1'b0, src_i};
      nxt_result = sum[15:0];
      nxt_ccr[calsu_pkg::FLAG_C] = sum[16];
      nxt_ccr[calsu_pkg::FLAG_V] = sub ? (dst_i[15] ^ src_i[15]) & (dst_i[15] ^ sum[15])
                                       : ~(dst_i[15] ^ src_i[15]) & (dst_i[15] ^ sum[15]);
      nxt_ccr[calsu_pkg::FLAG_Z] = (sum[15:0] == 16'h0000);
      nxt_ccr[calsu_pkg::FLAG_N] = sum[15];
    end
    else if (arith && !bad)
    begin
      // Carry only enters the with-carry pair; plus one and minus one keep C
      cin = cin && (op_i == calsu_pkg::OP_ADD_WITH_CARRY
                    || op_i == calsu_pkg::OP_SUBTRACT_WITH_BORROW);
      bsum = sub ? {1'b0, a} - {1'b0, b} - {8'h00, cin} : {1'b0, a} + {1'b0, b} + {8'h00, cin};
      hsum = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin}
                 : {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      nxt_result = {dst_i[15:8], bsum[7:0]};
      if (op_i != calsu_pkg::OP_PLUS_ONE && op_i != calsu_pkg::OP_MINUS_ONE_OP)
        nxt_ccr[calsu_pkg::FLAG_C] = bsum[8];
      nxt_ccr[calsu_pkg::FLAG_H] = hsum[4];
      nxt_ccr[calsu_pkg::FLAG_V] = sub ? (a[7] ^ b[7]) & (a[7] ^ bsum[7])
                                       : ~(a[7] ^ b[7]) & (a[7] ^ bsum[7]);
      // With-carry ops only ever clear Z so multi-byte zero tests chain
      if (op_i == calsu_pkg::OP_ADD_WITH_CARRY || op_i == calsu_pkg::OP_SUBTRACT_WITH_BORROW)
        nxt_ccr[calsu_pkg::FLAG_Z] = ccr_i[calsu_pkg::FLAG_Z] && (bsum[7:0] == 8'h00);
      else
        nxt_ccr[calsu_pkg::FLAG_Z] = (bsum[7:0] == 8'h00);
      nxt_ccr[calsu_pkg::FLAG_N] = bsum[7];
    end
    else if (logic_op)
    begin
      nxt_ccr[calsu_pkg::FLAG_Z] = (r8 == 8'h00);
      nxt_ccr[calsu_pkg::FLAG_N] = r8[7];
    end
    if (op_i == calsu_pkg::OP_COMPARE_OP || bad)
      nxt_result = dst_i;
    if (op_i == calsu_pkg::OP_COMPARE_OP || bad)
      nxt_wr_en = 1'b0;
    if (bad)
      nxt_ccr = ccr_i;
    nxt_illegal = start_i && bad;
    if (!start_i)
    begin
      nxt_result = result_ff;
      nxt_ccr = ccr_ff;
      nxt_wr_en = 1'b0;
      nxt_done = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      result_ff <= calsu_pkg::RESULT_RST;
      ccr_ff <= calsu_pkg::CCR_RST;
      wr_en_ff <= 1'b0;
      done_ff <= 1'b0;
      illegal_ff <= 1'b0;
    end
    else
    begin
      result_ff <= nxt_result;
      ccr_ff <= nxt_ccr;
      wr_en_ff <= nxt_wr_en;
      done_ff <= nxt_done;
      illegal_ff <= nxt_illegal;
    end
  end

  assign result_o = result_ff;
  assign ccr_o = ccr_ff;
  assign wr_en_o = wr_en_ff;
  assign done_o = done_ff;
  assign illegal_o = illegal_ff;

  chk_imm_sub_refused: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_SUB && imm_i |=> illegal_o && !wr_en_o)
    else $error("immediate subtract was not refused");
  chk_word_imm_refused: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && word_i && imm_i && op_i == calsu_pkg::OP_ADD |=> illegal_o)
    else $error("word immediate add was not refused");
  chk_carry_added: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_ADD_WITH_CARRY && !word_i |=>
    result_o[7:0] == 8'($past(dst_i[7:0]) + $past(src_i[7:0]) + 8'($past(ccr_i[0]))))
    else $error("add with carry result wrong");
  chk_step_value: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_WORD_SMALL_STEP_PLUS && src_i > 16'h0002 |=> illegal_o)
    else $error("small step of illegal size accepted");
  chk_mul_product: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_UNSIGNED_MULTIPLY |=>
    result_o == $past(dst_i[7:0]) * $past(src_i[7:0]) && wr_en_o)
    else $error("multiply product wrong");
  chk_cmp_no_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_COMPARE_OP |=> !wr_en_o && done_o)
    else $error("compare wrote a result");
  chk_neg_value: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_NEGATE && !word_i |=>
    result_o[7:0] == 8'(8'h00 - $past(dst_i[7:0])))
    else $error("negate result wrong");
  chk_not_value: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_NOT |=> result_o[7:0] == ~$past(dst_i[7:0]))
    else $error("not result wrong");
  chk_sar_sign: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_ARITH_SHIFT_RIGHT |=>
    result_o[7] == $past(dst_i[7]) && ccr_o[0] == $past(dst_i[0]))
    else $error("arithmetic right shift lost sign or carry");
  chk_rotc_carry: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    start_i && op_i == calsu_pkg::OP_ROTATE_LEFT_VIA_CARRY |=>
    ccr_o[0] == $past(dst_i[7]) && result_o[0] == $past(ccr_i[0]))
    else $error("rotate via carry wrong");
  cov_word_add: cover property (@(posedge clk_sys_i) start_i && word_i && op_i == calsu_pkg::OP_ADD);
  cov_divide: cover property (@(posedge clk_sys_i) start_i && op_i == calsu_pkg::OP_UNSIGNED_DIVIDE);
  cov_illegal: cover property (@(posedge clk_sys_i) illegal_o);
endmodule

// File: bench/calsu_issue_model.sv
/*
  Issue model standing in for the decoder and register file: presents one
  operation per call and scrambles the operand lines while idle.
  Assumes the caller steps it a short delay after a rising clock edge.
*/
`timescale 1ns/10ps
module calsu_issue_model (
  output logic start_o,
  output calsu_pkg::calsu_op_e op_o,
  output logic word_o,
  output logic imm_o,
  output logic [15:0] dst_o,
  output logic [15:0] src_o,
  output logic [7:0] flags_o
);
  initial
  begin
    start_o = 1'b0;
    op_o = calsu_pkg::OP_NONE;
    word_o = 1'b0;
    imm_o = 1'b0;
    dst_o = 16'h0000;
    src_o = 16'h0000;
    flags_o = 8'h00;
  end

  task automatic issue(input calsu_pkg::calsu_op_e op, input logic [1:0] wi,
    input logic [15:0] d, input logic [15:0] s, input logic [7:0] c);
    start_o = 1'b1;
    op_o = op;
    {word_o, imm_o} = wi;
    dst_o = d;
    src_o = s;
    flags_o = c;
  endtask

  // Stale operands would hide a design that samples without start
  task automatic idle();
    start_o = 1'b0;
    dst_o = ~dst_o;
    src_o = ~src_o;
    flags_o = ~flags_o;
  endtask
endmodule

// File: bench/test_cpu_arith_logic_shift_unit.sv
/*
  Self-checking bench for the arithmetic, logic and shift unit.
  Assumes the issue model drives operands and the result lands one cycle later.
*/
`timescale 1ns/10ps
module test_cpu_arith_logic_shift_unit;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start, word, imm, wr_en_o, done_o, illegal_o;
  calsu_pkg::calsu_op_e op;
  logic [15:0] dst, src, result_o;
  logic [7:0] cc_in, cc_out;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [7:0] SH_A [8] = '{8'h02, 8'hC0, 8'h02, 8'h40, 8'h03, 8'hC0, 8'h02, 8'h40};
  localparam logic [7:0] SH_B [8] = '{8'hFC, 8'h3F, 8'hFC, 8'h3F, 8'hFC, 8'h3F, 8'hFD, 8'hBF};

  always #4 clk_sys_i = ~clk_sys_i;

  calsu_issue_model u_part (.start_o(start), .op_o(op), .word_o(word), .imm_o(imm),
    .dst_o(dst), .src_o(src), .flags_o(cc_in));

  calsu_unit u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .start_i(start), .op_i(op),
    .word_i(word), .imm_i(imm), .dst_i(dst), .src_i(src), .ccr_i(cc_in), .result_o(result_o),
    .ccr_o(cc_out), .wr_en_o(wr_en_o), .done_o(done_o), .illegal_o(illegal_o));

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic fl(input int pos, input logic v);
    chk({15'h0, cc_out[pos]}, {15'h0, v}, "flag");
  endtask

  task automatic go(input calsu_pkg::calsu_op_e o, input logic [1:0] wi, input logic [15:0] d,
    input logic [15:0] s, input logic [7:0] c, input logic [15:0] exp, input logic wr,
    input logic ill);
    u_part.issue(o, wi, d, s, c);
    @(posedge clk_sys_i);
    #1;
    chk({15'h0, done_o}, 16'h0001, "done");
    chk({15'h0, wr_en_o}, {15'h0, wr}, "write");
    chk({15'h0, illegal_o}, {15'h0, ill}, "refuse");
    if (wr || ill)
      chk(result_o, exp, "result");
    if (ill)
      chk({8'h00, cc_out}, {8'h00, c}, "flags kept");
  endtask

  task automatic fin(input string name);
    u_part.idle();
    @(posedge clk_sys_i);
    #1;
    chk({15'h0, done_o}, 16'h0000, "done idle");
    $display("test %s finished", name);
  endtask

  task automatic t_add();
    go(calsu_pkg::OP_ADD, 2'h0, 16'h12FF, 16'h0001, 8'h00, 16'h1200, 1'b1, 1'b0);
    fl(calsu_pkg::FLAG_C, 1'b1);
    fl(calsu_pkg::FLAG_Z, 1'b1);
    go(calsu_pkg::OP_ADD, 2'h2, 16'h8000, 16'h8000, 8'h00, 16'h0000, 1'b1, 1'b0);
    fl(calsu_pkg::FLAG_V, 1'b1);
    go(calsu_pkg::OP_ADD, 2'h1, 16'h0010, 16'h0005, 8'h00, 16'h0015, 1'b1, 1'b0);
    go(calsu_pkg::OP_SUB, 2'h2, 16'h0003, 16'h0001, 8'h00, 16'h0002, 1'b1, 1'b0);
    fin("add");
  endtask

  task automatic t_refuse();
    go(calsu_pkg::OP_SUB, 2'h1, 16'h1234, 16'h0001, 8'h0A, 16'h1234, 1'b0, 1'b1);
    go(calsu_pkg::OP_ADD, 2'h3, 16'h1234, 16'h0001, 8'h05, 16'h1234, 1'b0, 1'b1);
    go(calsu_pkg::OP_ADD_WITH_CARRY, 2'h2, 16'h0101, 16'h0101, 8'h01, 16'h0101, 1'b0, 1'b1);
    go(calsu_pkg::OP_WORD_SMALL_STEP_PLUS, 2'h1, 16'h0100, 16'h0003, 8'h00, 16'h0100, 1'b0,
      1'b1);
    go(calsu_pkg::OP_UNSIGNED_DIVIDE, 2'h0, 16'h0100, 16'h0000, 8'h04, 16'h0100, 1'b0, 1'b1);
    go(calsu_pkg::OP_COMPARE_OP, 2'h3, 16'h0100, 16'h0100, 8'h08, 16'h0100, 1'b0, 1'b1);
    fin("refuse");
  endtask

  task automatic t_arith();
    go(calsu_pkg::OP_ADD_WITH_CARRY, 2'h1, 16'h0010, 16'h0020, 8'h01, 16'h0031, 1'b1, 1'b0);
    go(calsu_pkg::OP_SUBTRACT_WITH_BORROW, 2'h0, 16'h0010, 16'h0001, 8'h01, 16'h000E, 1'b1,
      1'b0);
    go(calsu_pkg::OP_PLUS_ONE, 2'h0, 16'h34FF, 16'h0000, 8'h01, 16'h3400, 1'b1, 1'b0);
    fl(calsu_pkg::FLAG_C, 1'b1);
    go(calsu_pkg::OP_MINUS_ONE_OP, 2'h0, 16'h3400, 16'h0000, 8'h00, 16'h34FF, 1'b1, 1'b0);
    go(calsu_pkg::OP_WORD_SMALL_STEP_PLUS, 2'h1, 16'hFFFF, 16'h0002, 8'h00, 16'h0001, 1'b1,
      1'b0);
    go(calsu_pkg::OP_WORD_SMALL_STEP_MINUS, 2'h1, 16'h0001, 16'h0002, 8'h00, 16'hFFFF, 1'b1,
      1'b0);
    go(calsu_pkg::OP_DECIMAL_FIX_AFTER_ADD, 2'h0, 16'h0041, 16'h0000, 8'h20, 16'h0047, 1'b1,
      1'b0);
    go(calsu_pkg::OP_DECIMAL_FIX_AFTER_SUB, 2'h0, 16'h001F, 16'h0000, 8'h20, 16'h0019, 1'b1,
      1'b0);
    go(calsu_pkg::OP_UNSIGNED_MULTIPLY, 2'h0, 16'h77FF, 16'h00FF, 8'h00, 16'hFE01, 1'b1, 1'b0);
    go(calsu_pkg::OP_UNSIGNED_DIVIDE, 2'h0, 16'h1234, 16'h0056, 8'h00, 16'h1036, 1'b1, 1'b0);
    go(calsu_pkg::OP_COMPARE_OP, 2'h1, 16'h0042, 16'h0042, 8'h00, 16'h0000, 1'b0, 1'b0);
    fl(calsu_pkg::FLAG_Z, 1'b1);
    go(calsu_pkg::OP_COMPARE_OP, 2'h2, 16'h1000, 16'h2000, 8'h00, 16'h0000, 1'b0, 1'b0);
    fl(calsu_pkg::FLAG_C, 1'b1);
    go(calsu_pkg::OP_NEGATE, 2'h0, 16'h5501, 16'h0000, 8'h00, 16'h55FF, 1'b1, 1'b0);
    fin("arith");
  endtask

  task automatic t_logic();
    go(calsu_pkg::OP_AND, 2'h1, 16'h003C, 16'h00F0, 8'h00, 16'h0030, 1'b1, 1'b0);
    go(calsu_pkg::OP_OR, 2'h0, 16'h003C, 16'h00F0, 8'h00, 16'h00FC, 1'b1, 1'b0);
    go(calsu_pkg::OP_XOR, 2'h1, 16'h003C, 16'h00F0, 8'h00, 16'h00CC, 1'b1, 1'b0);
    go(calsu_pkg::OP_NOT, 2'h0, 16'h005A, 16'h0000, 8'h00, 16'h00A5, 1'b1, 1'b0);
    fl(calsu_pkg::FLAG_N, 1'b1);
    fin("logic");
  endtask

  task automatic t_shift();
    calsu_pkg::calsu_op_e o;
    for (int i = 0; i < 8; i++)
    begin
      o = calsu_pkg::calsu_op_e'(calsu_pkg::OP_ARITH_SHIFT_LEFT + i);
      go(o, 2'h0, 16'hAB81, 16'h0000, 8'h00, {8'hAB, SH_A[i]}, 1'b1, 1'b0);
      fl(calsu_pkg::FLAG_C, 1'b1);
      go(o, 2'h0, 16'h007E, 16'h0000, 8'h01, {8'h00, SH_B[i]}, 1'b1, 1'b0);
      fl(calsu_pkg::FLAG_C, 1'b0);
    end
    fin("shift");
  endtask

  task automatic t_reset();
    u_part.issue(calsu_pkg::OP_NONE, 2'h0, 16'h0001, 16'h0001, 8'h00);
    @(posedge clk_sys_i);
    #1;
    chk({15'h0, done_o}, 16'h0000, "no op");
    sys_rst_i = 1'b1;
    u_part.idle();
    @(posedge clk_sys_i);
    #1;
    chk(result_o, calsu_pkg::RESULT_RST, "reset result");
    chk({8'h00, cc_out}, {8'h00, calsu_pkg::CCR_RST}, "reset flags");
    sys_rst_i = 1'b0;
    go(calsu_pkg::OP_ADD, 2'h0, 16'h0001, 16'h0002, 8'h00, 16'h0003, 1'b1, 1'b0);
    fin("reset");
  endtask

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    #1;
    sys_rst_i = 1'b0;
    t_add();
    t_refuse();
    t_arith();
    t_logic();
    t_shift();
    t_reset();
    end_of_test();
  end
endmodule
